// ===== lbc_pkg.sv
// Purpose: Shared constants and carrier types of the lamp brightness control block.
// Assumes: Core clock of 20 MHz; serial link clocked by its own bus clock.
// Notes:   Latch reset values, the counter preset and the switching period counts are named here once.
package lbc_pkg;

    // Core clock rate and the two switching rates of the power switch.
    localparam int CLK_HZ    = 20000000;
    localparam int FSW_LO_HZ = 145000;
    localparam int FSW_HI_HZ = 290000;

    // Cycles per switching period; the rate is not a bound, so it is truncated.
    localparam logic [7:0] PER_LO_CYC = 8'(CLK_HZ / FSW_LO_HZ);
    localparam logic [7:0] PER_HI_CYC = 8'(CLK_HZ / FSW_HI_HZ);

    // Brightness code limits and the mid-scale preset.
    localparam logic [4:0] CODE_MID  = 5'h10;
    localparam logic [4:0] CODE_MAX  = 5'h1F;
    localparam logic [4:0] CODE_ZERO = 5'h00;

    // Serial slave address and byte framing.
    localparam logic [6:0] SLAVE_ADDR  = 7'h2D;
    localparam int         TARGET_BIT  = 7;
    localparam logic [3:0] LAST_BIT    = 4'h7;
    localparam logic [3:0] ACK_BIT     = 4'h8;
    localparam logic [1:0] STATUS_ONES = 2'h3;

    // One configuration latch: full power-down (low active), standby, code.
    typedef struct packed {
        logic       full_off_n;
        logic       lamp_hold_n;
        logic [4:0] dim_code;
    } lbc_cfg_t;

    // Reset contents of the two latches.
    localparam lbc_cfg_t CFG0_RST = '{full_off_n: 1'b0, lamp_hold_n: 1'b0, dim_code: CODE_MID};
    localparam lbc_cfg_t CFG1_RST = '{full_off_n: 1'b1, lamp_hold_n: 1'b1, dim_code: CODE_MID};

    // Byte returned on a read.
    typedef struct packed {
        logic       open_lamp_ok_flag;
        logic [1:0] ones;
        logic [4:0] active_dim_code;
    } lbc_status_t;

    // Pins that enter the core clock domain through the synchroniser.
    typedef struct packed {
        logic scl;
        logic sda;
        logic up;
        logic dn;
        logic sync;
        logic otp;
        logic cs;
        logic fref;
        logic pdn_n;
        logic lsel;
    } lbc_pins_t;

    // Phases of the serial link within one frame.
    typedef enum logic [1:0] {PH_ADDR, PH_WRITE, PH_READ, PH_SKIP} lbc_phase_t;

endpackage

// ===== lbc_link.sv
// Purpose: Bus-clock side of the serial slave: shifts bytes, acknowledges, returns status.
// Assumes: link_rst is held while the bus is idle, so each frame starts clean.
// Notes:   Data is sampled on rising bus clock edges and driven on falling ones.
`timescale 1ns/1ps
module lbc_link
(
    input  wire logic                scl,
    input  wire logic                link_rst,
    input  wire logic                core_rst,
    input  wire logic                sda_in,
    input  lbc_pkg::lbc_status_t     status,
    output logic                     sda_oe_n,
    output logic                     wr_toggle,
    output logic [7:0]               wr_byte
);
    import lbc_pkg::*;

    lbc_phase_t phase_q, phase_d;
    logic [3:0] bit_q,   bit_d;
    logic [7:0] sh_q,    sh_d;
    logic       ack_q,   ack_d;
    logic       tgl_q,   tgl_d;
    logic [7:0] byte_q,  byte_d;
    logic       oe_n_q,  oe_n_d;
    logic [7:0] shifted;
    logic [7:0] tx_word;

    assign tx_word = status;

    // Bit counter, shifter and frame phase; the address decides whether we answer.
    always_comb
    begin
        shifted = {sh_q[6:0], sda_in};
        phase_d = phase_q;
        bit_d   = bit_q;
        sh_d    = sh_q;
        ack_d   = ack_q;
        tgl_d   = tgl_q;
        byte_d  = byte_q;
        if (bit_q == ACK_BIT)
        begin
            bit_d = 4'h0;
            ack_d = 1'b0;
            if (phase_q == PH_READ && sda_in)
            begin
                phase_d = PH_SKIP;   // Host declined more data.
            end
        end
        else
        begin
            sh_d  = shifted;
            bit_d = bit_q + 4'h1;
            if (bit_q == LAST_BIT)
            begin
                unique case (phase_q)
                    PH_ADDR:
                    begin
                        if (shifted[7:1] == SLAVE_ADDR)
                        begin
                            ack_d   = 1'b1;
                            phase_d = shifted[0] ? PH_READ : PH_WRITE;
                        end
                        else
                        begin
                            phase_d = PH_SKIP;
                        end
                    end
                    PH_WRITE:
                    begin
                        ack_d  = 1'b1;
                        byte_d = shifted;
                        tgl_d  = ~tgl_q;
                    end
                    PH_READ:
                    begin
                        ack_d = 1'b0;
                    end
                    PH_SKIP:
                    begin
                        ack_d = 1'b0;
                    end
                endcase
            end
        end
    end

    // Rising-edge state; cleared whenever the bus is idle.
    always_ff @(posedge scl or posedge link_rst)
    begin
        if (link_rst)
        begin
            phase_q <= PH_ADDR;
            bit_q   <= 4'h0;
            sh_q    <= 8'h00;
            ack_q   <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            ack_q   <= ack_d;
        end
    end

    // The toggle and its byte must survive idle, so only the core reset clears them.
    // Clearing them on bus idle would flip the toggle and replay a zero byte into latch zero.
    always_ff @(posedge scl or posedge core_rst)
    begin
        if (core_rst)
        begin
            tgl_q  <= 1'b0;
            byte_q <= 8'h00;
        end
        else
        begin
            tgl_q  <= tgl_d;
            byte_q <= byte_d;
        end
    end

    // Pull the line low for our acknowledge and for zero bits of the status byte.
    always_comb
    begin
        oe_n_d = ~((bit_q == ACK_BIT && ack_q) ||
                   (phase_q == PH_READ && bit_q != ACK_BIT && !tx_word[3'(LAST_BIT - bit_q)]));
    end

    // Driven on the falling edge so the line is settled before the host samples.
    always_ff @(negedge scl or posedge link_rst)
    begin
        if (link_rst)
        begin
            oe_n_q <= 1'b1;
        end
        else
        begin
            oe_n_q <= oe_n_d;
        end
    end

    assign sda_oe_n  = oe_n_q;
    assign wr_toggle = tgl_q;
    assign wr_byte   = byte_q;

endmodule

// ===== lbc_core.sv
// Purpose: Digital control of a lamp backlight driver: brightness front ends and switch gating.
// Assumes: 20 MHz core clock; serial bus clock is its own domain; analog parts are outside.
// Notes:   SERIAL_VARIANT picks the serial front end (1) or the pulse counter (0).
//
// What this block does
// - Force the power switch off while the open-tube comparator is high.
// - Switch turns on each period start, off at the current limit.
// - Discharge soft-start during power-on reset and whenever the lamp is off.
// - Frequency pin low selects 145 kHz, high (reference) selects 290 kHz.
// - Each rising sync edge restarts the cycle and turns the switch on.
// - Pulse variant keeps a 5-bit up/down counter driving the code.
// - Counter presets to mid-scale at reset and when both inputs high.
// - Each rising increment edge raises the counter by one.
// - Each rising decrement edge lowers the counter by one.
// - Counter saturates at both ends, never wraps.
// - Power-down pin low turns analog off but keeps counter and interface.
// - Serial variant stores two 7-bit latches from single-byte writes.
// - Only address 0101101 is acknowledged and acted upon.
// - Byte with top bit zero loads latch zero only.
// - Selected full-power-down bit zero shuts the analog section down.
// - Full power-down overrides the standby bit.
// - Selected standby bit zero holds switch off and soft-start grounded.
// - Selected latch code bits drive the brightness code.
// - Latch zero resets to power-down, standby, mid-scale.
// - Top bit one loads latch one, which resets to on, active, mid-scale.
// - Read returns open-lamp-ok flag, two ones, and the active code.
`timescale 1ns/1ps
module lbc_core
#(
    parameter bit SERIAL_VARIANT = 1'b1
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        up_pin,
    input  wire logic        decrement_pin,
    input  wire logic        sync_pin,
    input  wire logic        open_tube_cmp,
    input  wire logic        cur_limit_cmp,
    input  wire logic        freq_ref_pin,
    input  wire logic        power_down_pin_n,
    input  wire logic        latch_select_pin,
    output logic             power_switch,
    output logic             ss_discharge,
    output logic             analog_on,
    output logic [4:0]       active_dim_code
);
    import lbc_pkg::*;

    lbc_pins_t   pins_raw;
    lbc_pins_t   meta_q;
    lbc_pins_t   sync_q;
    lbc_pins_t   prev_q;
    logic        idle_q,  idle_d;
    logic        link_rst;
    logic        start_det;
    logic        stop_det;
    logic        wr_toggle;
    logic [7:0]  wr_byte;
    logic [2:0]  tgl_q;
    logic        wr_evt;
    lbc_cfg_t    cfg0_q,  cfg0_d;
    lbc_cfg_t    cfg1_q,  cfg1_d;
    lbc_cfg_t    cfg_sel;
    logic [4:0]  cnt_q,   cnt_d;
    logic        up_rise;
    logic        dn_rise;
    logic        both_hi;
    logic [4:0]  code;
    logic        shutdown;
    logic        standby;
    logic        lamp_off;
    logic        ok_q,    ok_d;
    lbc_status_t stat_q,  stat_d;
    logic [7:0]  per_q,   per_d;
    logic [7:0]  per_max;
    logic        restart;
    logic        sw_q,    sw_d;
    logic        por_q;
    logic        ss_q,    ss_d;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Gather every outside level for the synchroniser; the link itself reads scl and sda_in directly.
    assign pins_raw = '{scl: scl, sda: sda_in, up: up_pin, dn: decrement_pin,
                        sync: sync_pin, otp: open_tube_cmp, cs: cur_limit_cmp,
                        fref: freq_ref_pin, pdn_n: power_down_pin_n, lsel: latch_select_pin};

    // Two-stage synchroniser plus a history stage; sync_q and prev_q feed logic.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge events from the synchronised pulse inputs.
    assign up_rise = sync_q.up & ~prev_q.up;
    assign dn_rise = sync_q.dn & ~prev_q.dn;
    assign both_hi = sync_q.up & sync_q.dn;

    // Start and stop conditions seen on the synchronised bus lines.
    assign start_det = sync_q.scl & prev_q.scl & prev_q.sda & ~sync_q.sda;
    assign stop_det  = sync_q.scl & prev_q.scl & ~prev_q.sda & sync_q.sda;

    // Bus idle tracking; the link shifter is held in reset while the bus is idle.
    always_comb
    begin
        idle_d = idle_q;
        if (start_det)
        begin
            idle_d = 1'b0;
        end
        else if (stop_det)
        begin
            idle_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            idle_q <= 1'b1;
        end
        else
        begin
            idle_q <= idle_d;
        end
    end

    // Release is slow against the bus clock, which stays high after a start.
    assign link_rst = rst | idle_q | ~SERIAL_VARIANT;

    lbc_link u_link
    (
        .scl       (scl),
        .link_rst  (link_rst),
        .core_rst  (rst),
        .sda_in    (sda_in),
        .status    (stat_q),
        .sda_oe_n  (sda_oe_n),
        .wr_toggle (wr_toggle),
        .wr_byte   (wr_byte)
    );

    // Open-drain line: we only ever pull low.
    assign sda_out = 1'b0;

    // Written bytes cross as a toggle; the byte stays put for a whole byte time.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tgl_q <= 3'h0;
        end
        else
        begin
            tgl_q <= {tgl_q[1:0], wr_toggle};
        end
    end

    assign wr_evt = tgl_q[2] ^ tgl_q[1];

    // Configuration latches; the target bit of each byte picks one latch.
    always_comb
    begin
        cfg0_d = cfg0_q;
        cfg1_d = cfg1_q;
        if (wr_evt)
        begin
            if (!wr_byte[TARGET_BIT])
            begin
                cfg0_d = wr_byte[6:0];
            end
            else
            begin
                cfg1_d = wr_byte[6:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cfg0_q <= CFG0_RST;
            cfg1_q <= CFG1_RST;
        end
        else
        begin
            cfg0_q <= cfg0_d;
            cfg1_q <= cfg1_d;
        end
    end

    // The select pin only picks which latch drives the block; both keep their data.
    assign cfg_sel = sync_q.lsel ? cfg1_q : cfg0_q;

    // Saturating up/down counter; the preset wins over any edge.
    always_comb
    begin
        cnt_d = cnt_q;
        if (both_hi)
        begin
            cnt_d = CODE_MID;
        end
        else if (up_rise && cnt_q != CODE_MAX)
        begin
            cnt_d = cnt_q + 5'h01;
        end
        else if (dn_rise && cnt_q != CODE_ZERO)
        begin
            cnt_d = cnt_q - 5'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= CODE_MID;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // Operating state from the chosen front end; power-down never touches the counter.
    assign code     = SERIAL_VARIANT ? cfg_sel.dim_code : cnt_q;
    assign shutdown = SERIAL_VARIANT ? ~cfg_sel.full_off_n : ~sync_q.pdn_n;
    assign standby  = SERIAL_VARIANT & ~cfg_sel.lamp_hold_n & ~shutdown;
    assign lamp_off = (code == CODE_ZERO) | shutdown | standby;

    // Open-lamp flag: a trip clears it and beats the re-arm from shutdown or standby.
    always_comb
    begin
        ok_d = ok_q;
        if (sync_q.otp)
        begin
            ok_d = 1'b0;
        end
        else if (shutdown || standby)
        begin
            ok_d = 1'b1;
        end
    end

    // Status snapshot only moves while the bus is idle, so it is stable for a whole frame.
    always_comb
    begin
        stat_d = stat_q;
        if (idle_q)
        begin
            stat_d = '{open_lamp_ok_flag: ok_q, ones: STATUS_ONES, active_dim_code: code};
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ok_q   <= 1'b1;
            stat_q <= '{open_lamp_ok_flag: 1'b1, ones: STATUS_ONES, active_dim_code: CODE_MID};
        end
        else
        begin
            ok_q   <= ok_d;
            stat_q <= stat_d;
        end
    end

    // Period counter; a sync edge restarts it early, so the faster source wins.
    assign per_max = sync_q.fref ? PER_HI_CYC - 8'h01 : PER_LO_CYC - 8'h01;
    assign restart = (per_q >= per_max) | (sync_q.sync & ~prev_q.sync);

    always_comb
    begin
        per_d = restart ? 8'h00 : per_q + 8'h01;
        sw_d  = sw_q;
        if (restart)
        begin
            sw_d = 1'b1;
        end
        else if (sync_q.cs)
        begin
            sw_d = 1'b0;
        end
        if (sync_q.otp || lamp_off || por_q)
        begin
            sw_d = 1'b0;
        end
    end

    // Soft-start is held down from reset until the lamp is on again.
    always_comb
    begin
        ss_d = por_q | lamp_off;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            per_q <= 8'h00;
            sw_q  <= 1'b0;
            por_q <= 1'b1;
            ss_q  <= 1'b1;
        end
        else
        begin
            per_q <= per_d;
            sw_q  <= sw_d;
            por_q <= 1'b0;
            ss_q  <= ss_d;
        end
    end

    assign power_switch    = sw_q;
    assign ss_discharge    = ss_q;
    assign analog_on       = ~shutdown;
    assign active_dim_code = code;

    // Checks on the switch, the counter and the latches.
    property p_otp_off;
        sync_q.otp |=> !sw_q;
    endproperty
    a_otp_off: assert property (p_otp_off) else $error("switch on after open-tube trip");

    property p_cs_off;
        sync_q.cs && !restart |=> !sw_q;
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("switch on past current limit");

    property p_ss_hold;
        lamp_off |=> ss_q;
    endproperty
    a_ss_hold: assert property (p_ss_hold) else $error("soft-start released while lamp off");

    property p_period;
        (per_q == 8'h00) && !sync_q.fref && !(sync_q.sync & ~prev_q.sync) ##1
            (!(sync_q.sync & ~prev_q.sync) && !sync_q.fref) [*8] |-> per_q == 8'h08;
    endproperty
    a_period: assert property (p_period) else $error("period counter stalled");

    property p_sync_on;
        (sync_q.sync & ~prev_q.sync) && !sync_q.otp && !lamp_off && !por_q |=> sw_q && per_q == 8'h00;
    endproperty
    a_sync_on: assert property (p_sync_on) else $error("sync edge did not restart cycle");

    property p_preset;
        both_hi |=> cnt_q == CODE_MID;
    endproperty
    a_preset: assert property (p_preset) else $error("counter not preset to mid-scale");

    property p_inc;
        up_rise && !both_hi && cnt_q != CODE_MAX |=> cnt_q == $past(cnt_q) + 5'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("increment edge missed");

    property p_sat;
        up_rise && !both_hi && cnt_q == CODE_MAX |=> cnt_q == CODE_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("counter wrapped at maximum");

    property p_latch0;
        wr_evt && !wr_byte[TARGET_BIT] |=> cfg0_q == $past(wr_byte[6:0]) && $stable(cfg1_q);
    endproperty
    a_latch0: assert property (p_latch0) else $error("latch zero write wrong");

    property p_flag;
        sync_q.otp |=> !ok_q;
    endproperty
    a_flag: assert property (p_flag) else $error("open-lamp flag not cleared");

    c_sync: cover property (sync_q.sync & ~prev_q.sync ##1 sw_q);
    c_latch1: cover property (wr_evt && wr_byte[TARGET_BIT]);
    c_preset: cover property (both_hi ##1 cnt_q == CODE_MID);
    c_cs_trip: cover property (sw_q ##1 sync_q.cs ##1 !sw_q);

endmodule

// ===== lbc_host.sv
// Purpose: Bus host model that writes and reads single bytes over the two-wire link.
// Assumes: The data line has a pull-up; the bus clock stands high between frames.
// Notes:   Bit period is 160 ns; start and stop keep the clock high for 300 ns.
`timescale 1ns/1ps
module lbc_host
(
    input  wire logic dev_oe_n,
    output logic      scl,
    output logic      sda
);
    logic low_q;

    // Wired-AND over the pull-up, so a released line reads high.
    assign sda = ~(low_q | ~dev_oe_n);

    // Bus idles released with the clock parked high.
    initial
    begin
        scl = 1'b1;
        low_q = 1'b0;
    end

    // One bit: data changes while the clock is low and is read in mid-high.
    task automatic bit_io(input logic b, output logic r);
        low_q = ~b;
        #80 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
    endtask

    // Eight bits MSB first, then the ninth clock returns the acknowledge.
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Whole frame; a refused address skips the data phase.
    task automatic frame(input logic [6:0] adr, input logic rd, input logic [7:0] wv,
                         output logic ack, output logic [7:0] rv);
        logic r;
        logic a2;
        rv = 8'h00;
        low_q = 1'b1;
        #300 scl = 1'b0;
        put_byte({adr, rd}, ack);
        if (ack && !rd)
        begin
            put_byte(wv, a2);
            ack = a2;
        end
        if (ack && rd)
        begin
            for (int i = 7; i >= 0; i--)
                bit_io(1'b1, rv[i]);
            bit_io(1'b1, r);
        end
        low_q = 1'b1;
        #80 scl = 1'b1;
        #300 low_q = 1'b0;
        #300;
    endtask
endmodule

// ===== tb_lbc_core.sv
// Purpose: Self-checking bench for both front ends of the lamp brightness control.
// Assumes: Serial instance talks to the host model; the pulse instance is driven here.
// Notes:   Current limit is modelled as rising ten cycles after the switch closes.
`timescale 1ns/1ps
module tb_lbc_core;
    import lbc_pkg::*;
    logic       mclk, rst, up, dn, sync, otp, cs, fref, pdn_n, lsel;
    logic       scl, sda, s_oe_n, s_sw, s_ss, s_an, p_sw, p_ss, p_an;
    logic [4:0] s_code, p_code;
    logic [3:0] on_cnt;
    logic [7:0] n;
    int         fail_count, comparisons, cycles;

    lbc_core #(.SERIAL_VARIANT(1'b1)) lbc_core_i (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda),
        .sda_out(), .sda_oe_n(s_oe_n), .up_pin(up), .decrement_pin(dn), .sync_pin(sync),
        .open_tube_cmp(otp), .cur_limit_cmp(cs), .freq_ref_pin(fref), .power_down_pin_n(pdn_n),
        .latch_select_pin(lsel), .power_switch(s_sw), .ss_discharge(s_ss), .analog_on(s_an),
        .active_dim_code(s_code));
    lbc_core #(.SERIAL_VARIANT(1'b0)) lbc_core_pulse_i (.mclk(mclk), .rst(rst), .scl(1'b1),
        .sda_in(1'b1), .sda_out(), .sda_oe_n(), .up_pin(up), .decrement_pin(dn), .sync_pin(sync),
        .open_tube_cmp(otp), .cur_limit_cmp(cs), .freq_ref_pin(fref), .power_down_pin_n(pdn_n),
        .latch_select_pin(lsel), .power_switch(p_sw), .ss_discharge(p_ss), .analog_on(p_an),
        .active_dim_code(p_code));
    lbc_host lbc_host_i (.dev_oe_n(s_oe_n), .scl(scl), .sda(sda));

    // Core clock at 20 MHz.
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Current sense rises after the switch has been on a while; a hang is cut short.
    always @(posedge mclk)
    begin
        on_cnt <= s_sw ? on_cnt + 4'h1 : 4'h0;
        cs <= s_sw && on_cnt > 4'h8;
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    task automatic clk(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task automatic wr(input logic [6:0] adr, input logic [7:0] v, input logic exp);
        logic a;
        logic [7:0] rv;
        lbc_host_i.frame(adr, 1'b0, v, a, rv);
        check("ack", a, exp);
        clk(6);
    endtask

    task automatic rd(input logic [7:0] exp);
        logic a;
        logic [7:0] rv;
        lbc_host_i.frame(SLAVE_ADDR, 1'b1, 8'h00, a, rv);
        check("status", rv, exp);
    endtask

    // Counts cycles until the next rising switch edge, 255 when none comes.
    task automatic rise_gap(output logic [7:0] g);
        logic lo;
        lo = 1'b0;
        g = 8'h00;
        do
        begin
            @(negedge mclk);
            g++;
            lo = lo | ~s_sw;
        end while (!(lo && s_sw === 1'b1) && g != 8'hFF);
    endtask

    task automatic pulse(input logic u, input logic d);
        @(posedge mclk);
        up <= u;
        dn <= d;
        clk(4);
        @(posedge mclk);
        up <= 1'b0;
        dn <= 1'b0;
        clk(4);
    endtask

    task automatic t_reset();
        check("code0", s_code, CODE_MID);
        check("analog0", s_an, 1'b0);
        check("ss0", s_ss, 1'b1);
        check("sw0", s_sw, 1'b0);
        check("cnt0", p_code, CODE_MID);
        @(posedge mclk);
        lsel <= 1'b1;
        clk(4);
        check("code1", s_code, CODE_MID);
        check("analog1", s_an, 1'b1);
        rd(8'hF0);
        $display("test reset done");
    endtask

    task automatic t_latches();
        wr(SLAVE_ADDR, 8'hC0, 1'b1);
        check("l1 code", s_code, CODE_ZERO);
        check("l1 ss", s_ss, 1'b1);
        rise_gap(n);
        check("l1 hold", n, 8'hFF);
        check("l1 ref", s_an, 1'b1);
        wr(SLAVE_ADDR, 8'hBF, 1'b1);
        check("l1 off", s_an, 1'b0);
        @(posedge mclk);
        lsel <= 1'b0;
        clk(4);
        check("l0 kept", s_code, CODE_MID);
        wr(SLAVE_ADDR, 8'h7F, 1'b1);
        check("l0 code", s_code, CODE_MAX);
        check("l0 on", s_an, 1'b1);
        wr(7'h2C, 8'h00, 1'b0);
        check("foreign", s_code, CODE_MAX);
        wr(SLAVE_ADDR, 8'h3F, 1'b1);
        check("l0 off", s_an, 1'b0);
        wr(SLAVE_ADDR, 8'h7F, 1'b1);
        $display("test latches done");
    endtask

    task automatic t_switch();
        rise_gap(n);
        rise_gap(n);
        check("per lo", n, PER_LO_CYC);
        check("ss run", s_ss, 1'b0);
        @(posedge mclk);
        fref <= 1'b1;
        rise_gap(n);
        rise_gap(n);
        check("per hi", n, PER_HI_CYC);
        clk(20);
        check("cs off", s_sw, 1'b0);
        @(posedge mclk);
        sync <= 1'b1;
        rise_gap(n);
        check("sync", n <= 8'h06, 1'b1);
        @(posedge mclk);
        sync <= 1'b0;
        otp <= 1'b1;
        rise_gap(n);
        check("otp", n, 8'hFF);
        rd(8'h7F);
        @(posedge mclk);
        otp <= 1'b0;
        wr(SLAVE_ADDR, 8'h5F, 1'b1);
        wr(SLAVE_ADDR, 8'h7F, 1'b1);
        rd(8'hFF);
        $display("test switch done");
    endtask

    task automatic t_pulse();
        repeat (15) pulse(1'b1, 1'b0);
        check("up", p_code, CODE_MAX);
        pulse(1'b1, 1'b0);
        check("up sat", p_code, CODE_MAX);
        repeat (31) pulse(1'b0, 1'b1);
        check("dn", p_code, CODE_ZERO);
        check("dark ss", p_ss, 1'b1);
        pulse(1'b0, 1'b1);
        check("dn sat", p_code, CODE_ZERO);
        pulse(1'b1, 1'b1);
        check("both", p_code, CODE_MID);
        @(posedge mclk);
        pdn_n <= 1'b0;
        pulse(1'b1, 1'b0);
        check("pd analog", p_an, 1'b0);
        check("pd count", p_code, 5'h11);
        check("pd sw", p_sw, 1'b0);
        @(posedge mclk);
        pdn_n <= 1'b1;
        $display("test pulse done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence after a six-cycle reset.
    initial
    begin
        {up, dn, sync, otp, fref, lsel} = 6'h00;
        pdn_n = 1'b1;
        {fail_count, comparisons, cycles} = '0;
        rst = 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        clk(4);
        t_reset();
        t_latches();
        t_switch();
        t_pulse();
        wrap_up();
    end
endmodule
